// ### logic/mailbox_pkg.sv
// Function
// - Low flag bits show unread add-on inbound bytes
// - Reading full inbound byte clears its flag
// - High flag bits show unread add-on outbound bytes
// - Write to full outbound byte silently overwrites
// - Outbound boxes are 32-bit, per-byte full flags
// - Both sides get separately enabled in/out interrupts
// - Only one chosen byte triggers each interrupt
// - Host ctrl bits 4,3:2,1:0 select outgoing trigger
// - Host ctrl bits 12,11:10,9:8 select incoming trigger
// - Any outbound byte write sets its flag
// - Writing one to flag reset clears all flags
// - Interrupt line asserts at second edge after add-on read or write
// - Interrupt line drops at second edge after host clear
// Shared constants and carriers for the mailbox block.
// Assumes one clock for both register ports and the interrupt lines.
package mailbox_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int BOXES  = 4;
  localparam int FLAGS  = 16;

  // Host port word indices
  localparam logic [3:0] IDX_H_OUT0   = 4'h0;
  localparam logic [3:0] IDX_H_IN0    = 4'h4;
  localparam logic [3:0] IDX_H_FLAGS  = 4'h8;
  localparam logic [3:0] IDX_H_IRQ    = 4'h9;
  localparam logic [3:0] IDX_H_MASTER = 4'hA;

  // Add-on port word indices
  localparam logic [3:0] IDX_A_IN0    = 4'h0;
  localparam logic [3:0] IDX_A_OUT0   = 4'h4;
  localparam logic [3:0] IDX_A_FLAGS  = 4'h8;
  localparam logic [3:0] IDX_A_GEN    = 4'h9;
  localparam logic [3:0] IDX_A_IRQ    = 4'hA;

  // Interrupt control fields, host layout; add-on uses bits 4:0 for in, 12:8 for out
  localparam int IRQ_OUT_EN_BIT  = 4;
  localparam int IRQ_OUT_BOX_LSB = 2;
  localparam int IRQ_OUT_BYTE_LSB = 0;
  localparam int IRQ_IN_EN_BIT   = 12;
  localparam int IRQ_IN_BOX_LSB  = 10;
  localparam int IRQ_IN_BYTE_LSB = 8;
  localparam int IRQ_OUT_STAT_BIT = 16;
  localparam int IRQ_IN_STAT_BIT  = 17;
  localparam int FLAG_RESET_BIT   = 27;

  localparam logic [31:0] BOX_RESET  = 32'h0000_0000;
  localparam logic [15:0] FLAG_RESET = 16'h0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int RESP_DEPTH = 4;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [3:0]        be;
    logic [DATA_W-1:0] wdata;
  } regReq_t;

  typedef struct packed {
    logic       en;
    logic [1:0] box;
    logic [1:0] byteSel;
  } trigCfg_t;

endpackage

// ### logic/fifo_buffer.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/1ns
module fifo_buffer
  import mailbox_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wrPtr_reg;
  logic [PW-1:0]    rdPtr_reg;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             ready_reg;
  logic             valid_reg;

  wire push = inValid & ready_reg;
  wire pop  = outReady & valid_reg;

  assign count_next = count_reg + CW'(push) - CW'(pop);
  // Both handshake flags straight from flops; not ready while in reset
  assign inReady  = ready_reg;
  assign outValid = valid_reg;
  assign outData  = mem_reg[rdPtr_reg];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
      valid_reg <= 1'b0;
    end else begin
      if (push) wrPtr_reg <= (wrPtr_reg == PTR_LAST) ? '0 : wrPtr_reg + 1'b1;
      if (pop) rdPtr_reg <= (rdPtr_reg == PTR_LAST) ? '0 : rdPtr_reg + 1'b1;
      count_reg <= count_next;
      ready_reg <= (count_next != CNT_FULL);
      valid_reg <= (count_next != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_reg[wrPtr_reg] <= inData;
  end

endmodule

// ### logic/mailbox_status_interrupt.sv
// Bidirectional mailbox: four boxes each way, per-byte flags, interrupts.
// Assumes host and add-on register ports share clk; host reads are
// answered through a response FIFO that the host side drains.
`timescale 1ns/1ns
module mailbox_status_interrupt
  import mailbox_pkg::*;
#(
  parameter int RESP_FIFO_DEPTH = RESP_DEPTH
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Host register port
  input  wire logic              hostReqValid,
  output logic                   hostReqReady,
  input  wire regReq_t           hostReq,
  output logic                   hostRspValid,
  input  wire logic              hostRspReady,
  output logic [DATA_W-1:0]      hostRdata,
  // Add-on register port
  input  wire regReq_t           addonReq,
  output logic                   addonRdValid,
  output logic [DATA_W-1:0]      addonRdata,
  // Interrupt lines
  output logic                   intaN,
  output logic                   irqN
);

  // Reset release through two flops
  logic rstMeta_reg;
  logic rst_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_reg <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rst_n       <= rstMeta_reg;
    end
  end

  // Per-byte mask of a box access, zero outside the box range
  function automatic logic [FLAGS-1:0] boxMask(input logic [3:0] addr,
                                               input logic [3:0] base,
                                               input logic [3:0] be);
    logic [FLAGS-1:0] m;
    m = '0;
    if (addr[3:2] == base[3:2]) m = {12'h000, be} << {addr[1:0], 2'b00};
    return m;
  endfunction

  // One-hot trigger byte, or nothing when disabled
  function automatic logic [FLAGS-1:0] trigMask(input trigCfg_t c);
    logic [FLAGS-1:0] m;
    m = '0;
    if (c.en) m = 16'h0001 << {c.box, c.byteSel};
    return m;
  endfunction

  function automatic logic [31:0] laneWrite(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Storage
  logic [DATA_W-1:0] hostToAddon_reg [BOXES];
  logic [DATA_W-1:0] addonToHost_reg [BOXES];
  logic [FLAGS-1:0]  inFlags_reg;
  logic [FLAGS-1:0]  inFlags_next;
  logic [FLAGS-1:0]  outFlags_reg;
  logic [FLAGS-1:0]  outFlags_next;
  logic [9:0]        hostCtrl_reg;
  logic [9:0]        addonCtrl_reg;
  logic [1:0]        hostStat_reg;
  logic [1:0]        hostStat_next;
  logic [1:0]        addonStat_reg;
  logic [1:0]        addonStat_next;

  // Request qualification
  wire hostTake = hostReqValid & hostReqReady;
  wire hostWr   = hostTake & hostReq.wr;
  wire hostRd   = hostTake & hostReq.rd & ~hostReq.wr;
  wire addonWr  = addonReq.wr;
  wire addonRd  = addonReq.rd & ~addonReq.wr;

  wire [FLAGS-1:0] hostWrMask  = hostWr ? boxMask(hostReq.addr, IDX_H_OUT0, hostReq.be) : '0;
  wire [FLAGS-1:0] hostRdMask  = hostRd ? boxMask(hostReq.addr, IDX_H_IN0, hostReq.be) : '0;
  wire [FLAGS-1:0] addonWrMask = addonWr ? boxMask(addonReq.addr, IDX_A_OUT0, addonReq.be) : '0;
  wire [FLAGS-1:0] addonRdMask = addonRd ? boxMask(addonReq.addr, IDX_A_IN0, addonReq.be) : '0;

  // Flag reset strobes from either side, write-only
  wire hostFlagReset  = hostWr & (hostReq.addr == IDX_H_MASTER)
                      & hostReq.wdata[FLAG_RESET_BIT];
  wire addonFlagReset = addonWr & (addonReq.addr == IDX_A_GEN)
                      & addonReq.wdata[FLAG_RESET_BIT];
  wire flagReset      = hostFlagReset | addonFlagReset;

  // Set beats clear and beats flag reset so no fresh byte is lost
  assign inFlags_next  = ((flagReset ? FLAG_RESET : inFlags_reg) & ~addonRdMask)
                       | hostWrMask;
  assign outFlags_next = ((flagReset ? FLAG_RESET : outFlags_reg) & ~hostRdMask)
                       | addonWrMask;

  // Trigger configuration
  wire trigCfg_t hostOutCfg  = {hostCtrl_reg[4], hostCtrl_reg[3:2], hostCtrl_reg[1:0]};
  wire trigCfg_t hostInCfg   = {hostCtrl_reg[9], hostCtrl_reg[8:7], hostCtrl_reg[6:5]};
  wire trigCfg_t addonInCfg  = {addonCtrl_reg[4], addonCtrl_reg[3:2], addonCtrl_reg[1:0]};
  wire trigCfg_t addonOutCfg = {addonCtrl_reg[9], addonCtrl_reg[8:7], addonCtrl_reg[6:5]};

  // Only the selected byte fires each interrupt
  wire hostOutHit  = |(trigMask(hostOutCfg) & addonRdMask);
  wire hostInHit   = |(trigMask(hostInCfg) & addonWrMask);
  wire addonOutHit = |(trigMask(addonOutCfg) & hostRdMask);
  wire addonInHit  = |(trigMask(addonInCfg) & hostWrMask);

  wire hostIrqWr  = hostWr & (hostReq.addr == IDX_H_IRQ);
  wire addonIrqWr = addonWr & (addonReq.addr == IDX_A_IRQ);
  wire [1:0] hostClr  = hostIrqWr ? {hostReq.wdata[IRQ_IN_STAT_BIT],
                                     hostReq.wdata[IRQ_OUT_STAT_BIT]} : 2'b00;
  wire [1:0] addonClr = addonIrqWr ? {addonReq.wdata[IRQ_IN_STAT_BIT],
                                      addonReq.wdata[IRQ_OUT_STAT_BIT]} : 2'b00;

  // Latched until a write of one clears; a new hit wins
  assign hostStat_next  = (hostStat_reg & ~hostClr) | {hostInHit, hostOutHit};
  assign addonStat_next = (addonStat_reg & ~addonClr) | {addonInHit, addonOutHit};

  // Register read views
  wire [31:0] addonFlagView = {outFlags_reg, inFlags_reg};
  wire [31:0] hostFlagView  = {outFlags_reg, inFlags_reg};
  wire [31:0] hostIrqView   = {14'h0000, hostStat_reg, 3'h0, hostCtrl_reg[9:5],
                               3'h0, hostCtrl_reg[4:0]};
  wire [31:0] addonIrqView  = {14'h0000, addonStat_reg, 3'h0, addonCtrl_reg[9:5],
                               3'h0, addonCtrl_reg[4:0]};

  // Flag reads only select a view; unmapped reads give zero
  wire [31:0] hostReadData =
      (hostReq.addr[3:2] == IDX_H_OUT0[3:2]) ? hostToAddon_reg[hostReq.addr[1:0]] :
      (hostReq.addr[3:2] == IDX_H_IN0[3:2])  ? addonToHost_reg[hostReq.addr[1:0]] :
      (hostReq.addr == IDX_H_FLAGS)          ? hostFlagView :
      (hostReq.addr == IDX_H_IRQ)            ? hostIrqView : 32'h0000_0000;
  wire [31:0] addonReadData =
      (addonReq.addr[3:2] == IDX_A_IN0[3:2])  ? hostToAddon_reg[addonReq.addr[1:0]] :
      (addonReq.addr[3:2] == IDX_A_OUT0[3:2]) ? addonToHost_reg[addonReq.addr[1:0]] :
      (addonReq.addr == IDX_A_FLAGS)          ? addonFlagView :
      (addonReq.addr == IDX_A_IRQ)            ? addonIrqView : 32'h0000_0000;

  // Read answers queue here so a slow host stalls new requests
  fifo_buffer #(
    .WIDTH (DATA_W),
    .DEPTH (RESP_FIFO_DEPTH)
  ) respFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (hostRd),
    .inReady  (hostReqReady),
    .inData   (hostReadData),
    .outValid (hostRspValid),
    .outReady (hostRspReady),
    .outData  (hostRdata)
  );

  // Mailbox data; writes to full bytes overwrite without complaint
  genvar b;
  generate
    for (b = 0; b < BOXES; b++) begin : g_box
      wire hostHit  = hostWr & (hostReq.addr == (IDX_H_OUT0 | 4'(b)));
      wire addonHit = addonWr & (addonReq.addr == (IDX_A_OUT0 | 4'(b)));
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hostToAddon_reg[b] <= BOX_RESET;
          addonToHost_reg[b] <= BOX_RESET;
        end else begin
          if (hostHit)
            hostToAddon_reg[b] <= laneWrite(hostToAddon_reg[b], hostReq.wdata, hostReq.be);
          if (addonHit)
            addonToHost_reg[b] <= laneWrite(addonToHost_reg[b], addonReq.wdata, addonReq.be);
        end
      end
    end
  endgenerate

  // Flags, control, status; flag register writes fall through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inFlags_reg   <= FLAG_RESET;
      outFlags_reg  <= FLAG_RESET;
      hostCtrl_reg  <= '0;
      addonCtrl_reg <= '0;
      hostStat_reg  <= 2'b00;
      addonStat_reg <= 2'b00;
    end else begin
      inFlags_reg   <= inFlags_next;
      outFlags_reg  <= outFlags_next;
      hostStat_reg  <= hostStat_next;
      addonStat_reg <= addonStat_next;
      if (hostIrqWr)
        hostCtrl_reg <= {hostReq.wdata[12:8], hostReq.wdata[4:0]};
      if (addonIrqWr)
        addonCtrl_reg <= {addonReq.wdata[12:8], addonReq.wdata[4:0]};
    end
  end

  // Lines follow latched status, two edges after the access that set it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      intaN        <= 1'b1;
      irqN         <= 1'b1;
      addonRdValid <= 1'b0;
      addonRdata   <= 32'h0000_0000;
    end else begin
      intaN        <= ~(|hostStat_reg);
      irqN         <= ~(|addonStat_reg);
      addonRdValid <= addonRd;
      if (addonRd) addonRdata <= addonReadData;
    end
  end

endmodule

// ### sim/mailbox_status_interrupt_chk.sv
// Port-level timing checks for the mailbox block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module mailbox_status_interrupt_chk
  import mailbox_pkg::*;
#(
  parameter int RESP_FIFO_DEPTH = RESP_DEPTH
) (
  // Clock and reset
  input logic              clk,
  input logic              arst_n,
  // Host port
  input logic              hostReqValid,
  input logic              hostReqReady,
  input regReq_t           hostReq,
  input logic              hostRspValid,
  input logic              hostRspReady,
  input logic [DATA_W-1:0] hostRdata,
  // Add-on port
  input regReq_t           addonReq,
  input logic              addonRdValid,
  input logic [DATA_W-1:0] addonRdata,
  // Interrupt lines
  input logic              intaN,
  input logic              irqN
);
  logic clrTake;
  logic addonAny;
  logic hostAny;
  assign clrTake  = hostReqValid && hostReqReady && hostReq.wr && hostReq.addr == IDX_H_IRQ;
  assign addonAny = addonReq.wr || addonReq.rd;
  assign hostAny  = hostReqValid && hostReqReady && (hostReq.wr || hostReq.rd);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_addon_rd_pulse: assert property (addonReq.rd && !addonReq.wr |=> addonRdValid)
    else $error("add-on read without valid pulse");
  a_addon_rdata_hold: assert property (!addonReq.rd |=> $stable(addonRdata))
    else $error("add-on read data moved without a read");
  a_host_rsp_follows: assert property (hostAny && hostReq.rd && !hostReq.wr |=> hostRspValid)
    else $error("host read gave no answer");
  a_host_rsp_stands: assert property (hostRspValid && !hostRspReady
    |=> hostRspValid && $stable(hostRdata))
    else $error("host answer dropped before pop");
  a_inta_cause: assert property ($fell(intaN) |-> $past(addonAny, 2))
    else $error("host interrupt without add-on access");
  a_irq_cause: assert property ($fell(irqN) |-> $past(hostAny, 2))
    else $error("add-on interrupt without host access");
  a_inta_latch: assert property (!intaN && !$past(clrTake) |=> !intaN)
    else $error("host interrupt released without clear");
  a_inta_clear: assert property (clrTake && hostReq.be[2] && hostReq.wdata[17:16] == 2'h3
    && !addonAny |=> ##1 intaN)
    else $error("host interrupt not released after clear");
  c_inta: cover property (!intaN);
  c_irq: cover property (!irqN);
  c_full: cover property (hostRspValid && !hostReqReady);
endmodule

bind mailbox_status_interrupt mailbox_status_interrupt_chk #(.RESP_FIFO_DEPTH(RESP_FIFO_DEPTH))
  u_chk (.clk(clk), .arst_n(arst_n), .hostReqValid(hostReqValid), .hostReqReady(hostReqReady),
    .hostReq(hostReq), .hostRspValid(hostRspValid), .hostRspReady(hostRspReady),
    .hostRdata(hostRdata), .addonReq(addonReq), .addonRdValid(addonRdValid),
    .addonRdata(addonRdata), .intaN(intaN), .irqN(irqN));

// ### sim/host_side_model.sv
// Host-side answer sink with a mix of prompt and slow pops.
// Assumes the bench may hold it off entirely through stall.
`timescale 1ns/1ns
module host_side_model (
  // Clock, reset, control
  input  logic clk,
  input  logic arst_n,
  input  logic stall,
  // Answer handshake
  output logic hostRspReady
);
  logic [2:0] pat_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) pat_reg <= 3'h1;
    else pat_reg <= {pat_reg[1:0], pat_reg[2] ^ pat_reg[1]};
  end
  assign hostRspReady = !stall && pat_reg[0];
endmodule

// ### sim/testbench.sv
// Self-checking bench: reference model of boxes, flags and interrupts.
// Assumes the package, design and host sink are compiled first.
`timescale 1ns/1ns
module testbench;
  import mailbox_pkg::*;
  logic              clk, arst_n, hostReqValid, hostRspReady, stall;
  logic              hostReqReady, hostRspValid, addonRdValid, intaN, irqN;
  regReq_t           hostReq, addonReq;
  logic [DATA_W-1:0] hostRdata, addonRdata, x, t, rs, flg;
  logic [31:0]       mb[2][4], cfg[2];
  logic [1:0]        stat[2];
  logic [31:0]       expQ[$];
  int                mismatches, total_checks, cyc, i, b, l;
  mailbox_status_interrupt u_dut (.clk(clk), .arst_n(arst_n), .hostReqValid(hostReqValid),
    .hostReqReady(hostReqReady), .hostReq(hostReq), .hostRspValid(hostRspValid),
    .hostRspReady(hostRspReady), .hostRdata(hostRdata), .addonReq(addonReq),
    .addonRdValid(addonRdValid), .addonRdata(addonRdata), .intaN(intaN), .irqN(irqN));
  host_side_model u_host (.clk(clk), .arst_n(arst_n), .stall(stall), .hostRspReady(hostRspReady));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] xs();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chkW(logic [31:0] g, logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Side s: 0 host, 1 add-on; box index bit 2 is the direction
  function automatic logic [31:0] mdl(bit s, bit w, logic [3:0] a, logic [3:0] be,
                                      logic [31:0] d);
    logic [31:0] r;
    logic [4:0]  f;
    r = 32'h0;
    f = 5'(cfg[!s] >> ((w ^ !s) ? 8 : 0));
    // Of box accesses, only writes of own outbound and reads of own inbound touch flags
    if (a < 4'h8 && a[2] != (s ^ w)) begin
      for (int k = 0; k < 4; k++) begin
        if (be[k] && w) mb[a[2]][a[1:0]][8*k+:8] = d[8*k+:8];
        if (be[k]) flg[16*a[2]+4*a[1:0]+k] = w;
      end
      if (f[4] && f[3:2] == a[1:0] && be[f[1:0]]) stat[!s][w] = 1'b1;
    end
    if (a < 4'h8) r = mb[a[2]][a[1:0]];
    if (a == 4'h8) r = flg;
    if (a == (s ? 4'hA : 4'h9)) begin
      if (w) begin
        cfg[s] = d & 32'h0000_1F1F;
        stat[s] &= ~d[17:16];
      end
      r = cfg[s] | {14'h0, stat[s], 16'h0};
    end
    if (w && a == (s ? 4'h9 : 4'hA) && d[27]) flg = 32'h0;
    return r;
  endfunction
  task automatic lines();
    chkW(intaN, !(|stat[0]));
    chkW(irqN, !(|stat[1]));
  endtask
  task automatic hostAcc(bit w, logic [3:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    #1 hostReqValid = 1'b1;
    hostReq = '{w, !w, a, be, d};
    while (hostReqReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    rs = mdl(0, w, a, be, d);
    if (!w) expQ.push_back(rs);
    @(posedge clk);
    #1 hostReqValid = 1'b0;
    @(posedge clk);
    #1 lines();
  endtask
  task automatic addonAcc(bit w, logic [3:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge clk);
    #1 addonReq = '{w, !w, a, be, d};
    rs = mdl(1, w, a, be, d);
    @(posedge clk);
    #1 addonReq.wr = 1'b0;
    addonReq.rd = 1'b0;
    if (!w) chkW(addonRdValid, 1'b1);
    if (!w) chkW(addonRdata, rs);
    @(posedge clk);
    #1 lines();
  endtask
  always @(posedge clk) begin
    cyc++;
    if (hostRspValid === 1'b1 && hostRspReady === 1'b1) chkW(hostRdata, expQ.pop_front());
    if (cyc > 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  initial begin
    x = 32'h0000_0028;
    {arst_n, hostReqValid, stall, hostReq, addonReq, flg} = '0;
    for (i = 0; i < 8; i++) mb[i/4][i%4] = 32'h0;
    cfg = '{32'h0, 32'h0};
    stat = '{2'h0, 2'h0};
    repeat (4) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge clk);
    hostAcc(0, 4'h8, 4'hF, 32'h0);
    hostAcc(0, 4'h9, 4'hF, 32'h0);
    hostAcc(0, 4'hB, 4'hF, 32'h0);
    for (b = 0; b < 4; b++) begin
      hostAcc(1, 4'(b), 4'hF, xs());
      addonAcc(0, 4'h8, 4'hF, 32'h0);
      addonAcc(0, 4'(b), 4'h5, 32'h0);
      addonAcc(0, 4'(b), 4'hA, 32'h0);
      addonAcc(1, 4'(4 + b), 4'hF, xs());
      addonAcc(1, 4'(4 + b), 4'(xs()), xs());
      hostAcc(0, 4'h8, 4'hF, 32'h0);
      hostAcc(0, 4'(4 + b), 4'hF, 32'h0);
    end
    hostAcc(1, 4'h1, 4'hF, xs());
    addonAcc(1, 4'h6, 4'h3, xs());
    hostAcc(0, 4'h1, 4'hF, 32'h0);
    addonAcc(0, 4'h6, 4'hF, 32'h0);
    hostAcc(1, 4'h8, 4'hF, 32'hFFFF_FFFF);
    hostAcc(1, 4'hA, 4'hF, 32'h0);
    addonAcc(0, 4'h8, 4'hF, 32'h0);
    hostAcc(1, 4'hA, 4'hF, 32'h0800_0000);
    addonAcc(1, 4'h5, 4'hF, xs());
    addonAcc(1, 4'h9, 4'hF, 32'h0800_0000);
    hostAcc(0, 4'h8, 4'hF, 32'h0);
    for (i = 0; i < 4; i++) begin
      t = xs() & 32'h0000_0F0F;
      b = t[11:10];
      l = t[9:8];
      hostAcc(1, 4'h9, 4'hF, t | 32'h1010);
      addonAcc(1, 4'(4 + b), 4'hF ^ 4'(1 << l), xs());
      addonAcc(1, 4'(4 + b), 4'(1 << l), xs());
      addonAcc(0, 4'(t[3:2]), 4'(1 << t[1:0]), 32'h0);
      hostAcc(0, 4'h9, 4'hF, 32'h0);
      hostAcc(1, 4'h9, 4'hF, t | 32'h0003_0000);
      addonAcc(1, 4'hA, 4'hF, t | 32'h1010);
      hostAcc(1, 4'(t[3:2]), 4'(1 << t[1:0]), xs());
      hostAcc(0, 4'(4 + b), 4'(1 << l), 32'h0);
      addonAcc(0, 4'hA, 4'hF, 32'h0);
      addonAcc(1, 4'hA, 4'hF, 32'h0003_0000);
    end
    // Answers pile up while the host holds off
    stall = 1'b1;
    repeat (4) hostAcc(0, 4'h8, 4'hF, 32'h0);
    chkW(hostReqReady, 1'b0);
    stall = 1'b0;
    hostAcc(0, 4'h9, 4'hF, 32'h0);
    for (i = 0; i < 50 && expQ.size() > 0; i++) @(posedge clk);
    chkW(expQ.size(), 32'h0);
    end_of_test();
  end
endmodule
